//--- tcm_pkg.sv
// Package of constants and types for the amplifier direct mode and chop math
package tcm_pkg;

    // ==========================================================
    // Register indexes (byte address is four times the index)
    localparam logic [9:0] IDX_MODE_A = 10'h042;
    localparam logic [9:0] IDX_CONN_A = 10'h043;
    localparam logic [9:0] IDX_MODE_B = 10'h044;
    localparam logic [9:0] IDX_CONN_B = 10'h045;
    localparam logic [9:0] IDX_MATH   = 10'h058;
    localparam logic [9:0] IDX_ACC_A  = 10'h060;
    localparam logic [9:0] IDX_ACC_B  = 10'h061;
    localparam logic [9:0] IDX_STATUS = 10'h062;

    // ==========================================================
    // Field positions
    localparam int MATH_A12_LSB  = 1;
    localparam int MATH_B12_LSB  = 5;
    localparam int MATH_BUF_BIT  = 7;
    localparam int MATH_A34_LSB  = 8;
    localparam int MATH_B34_LSB  = 10;
    localparam int MODE_BUF_BIT  = 7;
    localparam int MODE_GAIN_BIT = 9;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_PLSA_LSB = 1;
    localparam int STAT_PLSB_LSB = 3;
    localparam int STAT_CHAN_LSB = 5;
    localparam int STAT_SLOT_BIT = 7;

    // ==========================================================
    // Connection codes and reset values
    localparam logic [15:0] CONN_FILTER_OFF = 16'hAE65;
    localparam logic [15:0] CONN_DIRECT     = 16'hB065;
    localparam logic [15:0] RST_CONN        = 16'hADA5;
    localparam logic [15:0] RST_MODE        = 16'h1C00;
    localparam logic [15:0] RST_MATH        = 16'h0000;

    // ==========================================================
    // Widths and timing
    localparam int CODE_W          = 14;
    localparam int ACC_W           = 27;
    localparam int NUM_CHANNELS    = 4;
    localparam int CLK_PERIOD_NS   = 10;
    localparam int CONV_GAP_NS     = 1000;
    localparam int CONV_GAP_CYC    = CONV_GAP_NS / CLK_PERIOD_NS;

    // ==========================================================
    // Types
    typedef enum logic [0:0] {SEQ_IDLE, SEQ_RUN} tcm_seq_t;

    typedef struct packed {
        logic              valid;
        logic              slot;
        logic [CODE_W-1:0] code;
    } tcm_sample_t;

    typedef struct packed {
        logic bypass_filter;
        logic bypass_integ;
        logic integ_as_buf;
        logic gain_07;
        logic direct_mode;
    } tcm_path_t;

    typedef struct packed {
        logic [15:0]        mode_a;
        logic [15:0]        conn_a;
        logic [15:0]        mode_b;
        logic [15:0]        conn_b;
        logic [15:0]        math;
        logic [ACC_W-1:0]   acc_a;
        logic [ACC_W-1:0]   acc_b;
        logic [1:0]         pulse_a;
        logic [1:0]         pulse_b;
        logic               pready;
        logic               pslverr;
        logic [31:0]        prdata;
        tcm_path_t          path_a;
        tcm_path_t          path_b;
        tcm_seq_t           seq;
        logic [7:0]         seq_cnt;
        logic               conv_start;
        logic [1:0]         conv_chan;
        logic               conv_slot;
    } tcm_state_t;

endpackage : tcm_pkg

//--- tcm_top.sv
// Register file, chop math accumulators and direct-conversion sequencer
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps

module tcm_top #(
    parameter int CONV_GAP = tcm_pkg::CONV_GAP_CYC
) (
    input  wire logic                 CLOCK,
    input  wire logic                 RESET_N,
    input  wire logic [11:0]          PADDR,
    input  wire logic                 PSEL,
    input  wire logic                 PENABLE,
    input  wire logic                 PWRITE,
    input  wire logic [31:0]          PWDATA,
    output logic                      PREADY,
    output logic [31:0]               PRDATA,
    output logic                      PSLVERR,
    input  wire tcm_pkg::tcm_sample_t SAMPLE_IN,
    input  wire logic                 SLOT_START,
    input  wire logic                 SLOT_START_SEL,
    output tcm_pkg::tcm_path_t        SLOT_A_PATH,
    output tcm_pkg::tcm_path_t        SLOT_B_PATH,
    output logic                      CONV_START,
    output logic [1:0]                CONV_CHAN,
    output logic                      CONV_SLOT,
    output logic                      SEQ_BUSY
);

    // ==========================================================
    // Functions

    // Path settings from one slot's mode and connection registers and the shared math register
    function automatic tcm_pkg::tcm_path_t path_decode(
        input logic [15:0] mode,
        input logic [15:0] conn,
        input logic [15:0] math
    );
        tcm_pkg::tcm_path_t p;
        logic               off_flt;
        logic               direct;
        off_flt = (conn == tcm_pkg::CONN_FILTER_OFF);
        direct  = (conn == tcm_pkg::CONN_DIRECT);
        p.bypass_filter = off_flt | direct;
        p.bypass_integ  = direct;
        p.integ_as_buf  = off_flt & mode[tcm_pkg::MODE_BUF_BIT]
                          & math[tcm_pkg::MATH_BUF_BIT];
        p.gain_07       = mode[tcm_pkg::MODE_GAIN_BIT];
        p.direct_mode   = off_flt | direct;
        return p;
    endfunction : path_decode

    // High when the pulse at this index of the group is subtracted
    function automatic logic sub_sel(
        input logic [15:0] math,
        input logic        slot,
        input logic [1:0]  pulse
    );
        logic [1:0] pair;
        if (slot) begin
            pair = pulse[1] ? math[tcm_pkg::MATH_B34_LSB +: 2]
                            : math[tcm_pkg::MATH_B12_LSB +: 2];
        end else begin
            pair = pulse[1] ? math[tcm_pkg::MATH_A34_LSB +: 2]
                            : math[tcm_pkg::MATH_A12_LSB +: 2];
        end
        // Upper bit signs the first sample of a pair, lower the second
        return pulse[0] ? pair[0] : pair[1];
    endfunction : sub_sel

    // Signed update of an accumulator with one sample
    function automatic logic [tcm_pkg::ACC_W-1:0] acc_step(
        input logic [tcm_pkg::ACC_W-1:0]  acc,
        input logic [tcm_pkg::CODE_W-1:0] code,
        input logic                       sub
    );
        logic [tcm_pkg::ACC_W-1:0] ext;
        ext = {{(tcm_pkg::ACC_W - tcm_pkg::CODE_W){1'b0}}, code};
        return sub ? acc - ext : acc + ext;
    endfunction : acc_step

    // ==========================================================
    // State

    localparam logic [7:0] GAP_LAST = 8'(CONV_GAP - 1);

    tcm_pkg::tcm_state_t st_reg;
    tcm_pkg::tcm_state_t st_next;

    logic [9:0]  idx;
    logic        access;
    logic        commit;
    logic        wr_commit;
    logic        hit;
    logic [31:0] rd_value;
    logic        clr_a;
    logic        clr_b;
    logic        smp_sub;
    logic        start_ok;

    // ==========================================================
    // Next-state logic

    always_comb begin
        st_next = st_reg;
        idx     = PADDR[11:2];
        access  = PSEL & PENABLE;
        commit  = access & st_reg.pready;
        wr_commit = commit & PWRITE & ~st_reg.pslverr;
        clr_a   = 1'b0;
        clr_b   = 1'b0;
        smp_sub = 1'b0;
        start_ok = 1'b0;

        // Register read mux and address decode
        hit      = 1'b1;
        rd_value = 32'h0000_0000;
        unique case (idx)
            tcm_pkg::IDX_MODE_A: rd_value = {16'h0000, st_reg.mode_a};
            tcm_pkg::IDX_CONN_A: rd_value = {16'h0000, st_reg.conn_a};
            tcm_pkg::IDX_MODE_B: rd_value = {16'h0000, st_reg.mode_b};
            tcm_pkg::IDX_CONN_B: rd_value = {16'h0000, st_reg.conn_b};
            tcm_pkg::IDX_MATH:   rd_value = {16'h0000, st_reg.math};
            tcm_pkg::IDX_ACC_A:
                rd_value = 32'($signed(st_reg.acc_a));
            tcm_pkg::IDX_ACC_B:
                rd_value = 32'($signed(st_reg.acc_b));
            tcm_pkg::IDX_STATUS: begin
                rd_value[tcm_pkg::STAT_BUSY_BIT] =
                    (st_reg.seq == tcm_pkg::SEQ_RUN);
                rd_value[tcm_pkg::STAT_PLSA_LSB +: 2] = st_reg.pulse_a;
                rd_value[tcm_pkg::STAT_PLSB_LSB +: 2] = st_reg.pulse_b;
                rd_value[tcm_pkg::STAT_CHAN_LSB +: 2] = st_reg.conv_chan;
                rd_value[tcm_pkg::STAT_SLOT_BIT]      = st_reg.conv_slot;
            end
            default: hit = 1'b0;
        endcase
        if (PADDR[1:0] != 2'b00) begin
            hit = 1'b0;
        end

        // ======================================================
        // APB slave: one wait state, answer in second access cycle
        if (access & ~st_reg.pready) begin
            st_next.pready  = 1'b1;
            st_next.pslverr = ~hit;
            st_next.prdata  = (hit & ~PWRITE) ? rd_value : 32'h0000_0000;
        end else begin
            st_next.pready  = 1'b0;
            st_next.pslverr = 1'b0;
            st_next.prdata  = 32'h0000_0000;
        end

        // Register writes take effect at the edge that completes them
        if (wr_commit) begin
            unique case (idx)
                tcm_pkg::IDX_MODE_A: st_next.mode_a = PWDATA[15:0];
                tcm_pkg::IDX_CONN_A: st_next.conn_a = PWDATA[15:0];
                tcm_pkg::IDX_MODE_B: st_next.mode_b = PWDATA[15:0];
                tcm_pkg::IDX_CONN_B: st_next.conn_b = PWDATA[15:0];
                tcm_pkg::IDX_MATH:   st_next.math   = PWDATA[15:0];
                tcm_pkg::IDX_ACC_A:  clr_a = 1'b1;
                tcm_pkg::IDX_ACC_B:  clr_b = 1'b1;
                default: ;
            endcase
        end

        // ======================================================
        // Path settings, each slot decoded on its own mode and connection registers plus the shared math register
        st_next.path_a = path_decode(st_next.mode_a, st_next.conn_a,
                                     st_next.math);
        st_next.path_b = path_decode(st_next.mode_b, st_next.conn_b,
                                     st_next.math);

        // ======================================================
        // Accumulators; a clear by software loses no sample
        if (clr_a) begin
            st_next.acc_a = '0;
        end
        if (clr_b) begin
            st_next.acc_b = '0;
        end
        if (SLOT_START & ~SLOT_START_SEL) begin
            st_next.pulse_a = 2'b00;
        end
        if (SLOT_START & SLOT_START_SEL) begin
            st_next.pulse_b = 2'b00;
        end
        if (SAMPLE_IN.valid) begin
            if (SAMPLE_IN.slot) begin
                // Direct mode passes raw converter codes, no chop signs
                smp_sub = ~st_reg.path_b.direct_mode
                          & sub_sel(st_reg.math, 1'b1,
                                    st_reg.pulse_b);
                st_next.acc_b = acc_step(st_next.acc_b, SAMPLE_IN.code,
                                         smp_sub);
                st_next.pulse_b = st_reg.pulse_b + 2'd1;
            end else begin
                smp_sub = ~st_reg.path_a.direct_mode
                          & sub_sel(st_reg.math, 1'b0,
                                    st_reg.pulse_a);
                st_next.acc_a = acc_step(st_next.acc_a, SAMPLE_IN.code,
                                         smp_sub);
                st_next.pulse_a = st_reg.pulse_a + 2'd1;
            end
        end

        // ======================================================
        // Direct-conversion channel sequencer
        st_next.conv_start = 1'b0;
        start_ok = SLOT_START & (SLOT_START_SEL ? st_reg.path_b.direct_mode
                                                : st_reg.path_a.direct_mode);
        unique case (st_reg.seq)
            tcm_pkg::SEQ_IDLE: begin
                if (start_ok) begin
                    st_next.seq        = tcm_pkg::SEQ_RUN;
                    st_next.conv_start = 1'b1;
                    st_next.conv_chan  = 2'd0;
                    st_next.conv_slot  = SLOT_START_SEL;
                    st_next.seq_cnt    = GAP_LAST;
                end
            end
            tcm_pkg::SEQ_RUN: begin
                // Further starts are ignored until all channels are done
                if (st_reg.seq_cnt != 8'd0) begin
                    st_next.seq_cnt = st_reg.seq_cnt - 8'd1;
                end else if (st_reg.conv_chan !=
                             2'(tcm_pkg::NUM_CHANNELS - 1)) begin
                    st_next.conv_chan  = st_reg.conv_chan + 2'd1;
                    st_next.conv_start = 1'b1;
                    st_next.seq_cnt    = GAP_LAST;
                end else begin
                    st_next.seq = tcm_pkg::SEQ_IDLE;
                end
            end
        endcase
    end

    // ==========================================================
    // State register

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_reg.mode_a     <= tcm_pkg::RST_MODE;
            st_reg.conn_a     <= tcm_pkg::RST_CONN;
            st_reg.mode_b     <= tcm_pkg::RST_MODE;
            st_reg.conn_b     <= tcm_pkg::RST_CONN;
            st_reg.math       <= tcm_pkg::RST_MATH;
            st_reg.acc_a      <= '0;
            st_reg.acc_b      <= '0;
            st_reg.pulse_a    <= 2'b00;
            st_reg.pulse_b    <= 2'b00;
            st_reg.pready     <= 1'b0;
            st_reg.pslverr    <= 1'b0;
            st_reg.prdata     <= 32'h0000_0000;
            st_reg.path_a     <= '0;
            st_reg.path_b     <= '0;
            st_reg.seq        <= tcm_pkg::SEQ_IDLE;
            st_reg.seq_cnt    <= 8'h00;
            st_reg.conv_start <= 1'b0;
            st_reg.conv_chan  <= 2'b00;
            st_reg.conv_slot  <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // Outputs, all straight from the state register

    assign PREADY      = st_reg.pready;
    assign PRDATA      = st_reg.prdata;
    assign PSLVERR     = st_reg.pslverr;
    assign SLOT_A_PATH = st_reg.path_a;
    assign SLOT_B_PATH = st_reg.path_b;
    assign CONV_START  = st_reg.conv_start;
    assign CONV_CHAN   = st_reg.conv_chan;
    assign CONV_SLOT   = st_reg.conv_slot;
    assign SEQ_BUSY    = (st_reg.seq == tcm_pkg::SEQ_RUN);

endmodule : tcm_top

//--- tcm_chk.sv
// Checker of bus timing, path decode and conversion sequencing
`timescale 1ns/1ps

module tcm_chk #(
    parameter int CONV_GAP = tcm_pkg::CONV_GAP_CYC
) (
    input wire logic                 CLOCK,
    input wire logic                 RESET_N,
    input wire logic [11:0]          PADDR,
    input wire logic                 PSEL,
    input wire logic                 PENABLE,
    input wire logic                 PWRITE,
    input wire logic [31:0]          PWDATA,
    input wire logic                 PREADY,
    input wire logic [31:0]          PRDATA,
    input wire logic                 SLOT_START,
    input wire logic                 SLOT_START_SEL,
    input wire tcm_pkg::tcm_path_t   SLOT_A_PATH,
    input wire tcm_pkg::tcm_path_t   SLOT_B_PATH,
    input wire logic                 CONV_START,
    input wire logic [1:0]           CONV_CHAN,
    input wire logic                 CONV_SLOT,
    input wire logic                 SEQ_BUSY
);
    // ==========================================================
    // Helper state
    logic [7:0]  gap_cnt_reg;
    logic [1:0]  last_chan_reg;
    logic [15:0] wd_reg;
    logic        sel_direct;

    assign sel_direct = SLOT_START_SEL ? SLOT_B_PATH.direct_mode
                                       : SLOT_A_PATH.direct_mode;

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            gap_cnt_reg   <= 8'h00;
            last_chan_reg <= 2'h0;
            wd_reg        <= 16'h0000;
        end else begin
            gap_cnt_reg   <= CONV_START ? 8'h01 :
                             gap_cnt_reg == 8'hFF ? 8'hFF :
                             gap_cnt_reg + 8'h01;
            last_chan_reg <= CONV_START ? CONV_CHAN : last_chan_reg;
            wd_reg        <= PWDATA[15:0];
        end
    end

    // ==========================================================
    // Properties
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);

    sequence wr_s(logic [9:0] idx);
        PSEL && PENABLE && PREADY && PWRITE && PADDR == {idx, 2'b00};
    endsequence

    sequence seq_go_s;
        SLOT_START && !SEQ_BUSY && sel_direct;
    endsequence

    pready_wait_a: assert property (PSEL && !PENABLE |=> !PREADY ##1 PREADY)
        else $error("ready not after one wait state");
    pready_one_a: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    prdata_idle_a: assert property (!PREADY |-> PRDATA == 32'h0000_0000)
        else $error("read data outside answer");
    conv_first_a: assert property (seq_go_s |=> CONV_START && SEQ_BUSY
        && CONV_CHAN == 2'h0 && CONV_SLOT == $past(SLOT_START_SEL))
        else $error("sequence did not start on channel one");
    conv_refuse_a: assert property (SLOT_START && !SEQ_BUSY && !sel_direct
        |=> !CONV_START && !SEQ_BUSY)
        else $error("conversion started in normal mode");
    conv_gap_a: assert property (CONV_START && CONV_CHAN != 2'h0
        |-> gap_cnt_reg == CONV_GAP
        && CONV_CHAN == last_chan_reg + 2'h1)
        else $error("channel spacing or order wrong");
    busy_end_a: assert property ($fell(SEQ_BUSY)
        |-> last_chan_reg == 2'h3 && gap_cnt_reg == CONV_GAP)
        else $error("sequence ended early or late");
    conn_a_path_a: assert property (wr_s(tcm_pkg::IDX_CONN_A) |=>
        SLOT_A_PATH.bypass_integ == (wd_reg == tcm_pkg::CONN_DIRECT) &&
        SLOT_A_PATH.direct_mode == (wd_reg == tcm_pkg::CONN_DIRECT ||
                                    wd_reg == tcm_pkg::CONN_FILTER_OFF) &&
        SLOT_A_PATH.bypass_filter == SLOT_A_PATH.direct_mode)
        else $error("slot A path decode wrong");
    conn_b_path_a: assert property (wr_s(tcm_pkg::IDX_CONN_B) |=>
        $stable(SLOT_A_PATH) &&
        SLOT_B_PATH.bypass_integ == (wd_reg == tcm_pkg::CONN_DIRECT) &&
        SLOT_B_PATH.bypass_filter == (wd_reg == tcm_pkg::CONN_DIRECT
            || wd_reg == tcm_pkg::CONN_FILTER_OFF))
        else $error("slot B path decode wrong");
    gain_sel_a: assert property (wr_s(tcm_pkg::IDX_MODE_A) |=>
        SLOT_A_PATH.gain_07 == wd_reg[tcm_pkg::MODE_GAIN_BIT])
        else $error("gain select does not follow mode bit");
endmodule : tcm_chk

bind tcm_top tcm_chk #(.CONV_GAP(CONV_GAP)) u_chk (
    .CLOCK(CLOCK), .RESET_N(RESET_N), .PADDR(PADDR), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA), .PREADY(PREADY),
    .PRDATA(PRDATA), .SLOT_START(SLOT_START),
    .SLOT_START_SEL(SLOT_START_SEL), .SLOT_A_PATH(SLOT_A_PATH),
    .SLOT_B_PATH(SLOT_B_PATH), .CONV_START(CONV_START),
    .CONV_CHAN(CONV_CHAN), .CONV_SLOT(CONV_SLOT), .SEQ_BUSY(SEQ_BUSY));

//--- tcm_top_tb.sv
// Self-checking testbench of chop math and direct conversion control
`timescale 1ns/1ps

module tcm_top_tb;
    typedef struct packed {
        logic        slot;
        logic [15:0] math;
        logic [26:0] acc;
    } tcm_row_t;

    // Codes 1,2,4,8 per group, two groups: sums of signed powers of two
    localparam tcm_row_t ROWS [8] = '{
        '{1'b0, 16'h0300, -27'h000_0012}, '{1'b0, 16'h0202, 27'h000_0006},
        '{1'b0, 16'h0104, -27'h000_0006}, '{1'b0, 16'h0006, 27'h000_0012},
        '{1'b1, 16'h0000, 27'h000_001E}, '{1'b1, 16'h0420, -27'h000_000A},
        '{1'b1, 16'h0840, 27'h000_000A}, '{1'b1, 16'h0C60, -27'h000_001E}};

    logic                 CLOCK, RESET_N, PSEL, PENABLE, PWRITE, PREADY;
    logic                 PSLVERR, SLOT_START, SLOT_START_SEL, CONV_START;
    logic                 CONV_SLOT, SEQ_BUSY, er;
    logic [11:0]          PADDR;
    logic [31:0]          PWDATA, PRDATA, rd;
    logic [1:0]           CONV_CHAN;
    tcm_pkg::tcm_sample_t SAMPLE_IN;
    tcm_pkg::tcm_path_t   SLOT_A_PATH, SLOT_B_PATH;
    int                   err_total, cmp_count;

    tcm_top #(.CONV_GAP(4)) dut (
        .CLOCK(CLOCK), .RESET_N(RESET_N), .PADDR(PADDR), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA),
        .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
        .SAMPLE_IN(SAMPLE_IN), .SLOT_START(SLOT_START),
        .SLOT_START_SEL(SLOT_START_SEL), .SLOT_A_PATH(SLOT_A_PATH),
        .SLOT_B_PATH(SLOT_B_PATH), .CONV_START(CONV_START),
        .CONV_CHAN(CONV_CHAN), .CONV_SLOT(CONV_SLOT), .SEQ_BUSY(SEQ_BUSY));

    // ==========================================================
    // Helpers
    function automatic logic [11:0] ba(input logic [9:0] i);
        return {i, 2'b00};
    endfunction : ba

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t word got %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_flag(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t flag got %b expected %b", $time, got, exp);
        end
    endtask : chk_flag

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge CLOCK);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= wr;
        PADDR   <= a;
        PWDATA  <= wd;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLOCK);
            n++;
        end while (PREADY !== 1'b1 && n < 50);
        if (PREADY !== 1'b1) begin
            err_total++;
            $display("BAD %0t no ready from slave", $time);
        end
        rd = PRDATA;
        er = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk_word(rd, e);
    endtask : rd_chk

    task automatic start_pulse(input logic s);
        @(posedge CLOCK);
        SLOT_START     <= 1'b1;
        SLOT_START_SEL <= s;
        @(posedge CLOCK);
        SLOT_START     <= 1'b0;
    endtask : start_pulse

    task automatic send(input logic s, input logic [13:0] c);
        @(posedge CLOCK);
        SAMPLE_IN <= '{1'b1, s, c};
        @(posedge CLOCK);
        SAMPLE_IN <= '{1'b0, s, 14'h0000};
    endtask : send

    // A second start mid-sequence must be refused
    task automatic run_seq(input logic sel, input int exp_n);
        int n;
        n = 0;
        for (int i = 0; i < 35; i++) begin
            @(posedge CLOCK);
            SLOT_START     <= (i == 0 || i == 6);
            SLOT_START_SEL <= sel;
            #1;
            if (CONV_START === 1'b1) begin
                chk_word(32'(CONV_CHAN), 32'(n));
                chk_flag(CONV_SLOT, sel);
                n++;
            end
        end
        chk_word(32'(n), 32'(exp_n));
        chk_flag(SEQ_BUSY, 1'b0);
    endtask : run_seq

    task automatic give_verdict();
        $display("errors %0d comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict

    // ==========================================================
    // Clock, watchdog and main sequence
    initial begin
        CLOCK = 1'b0;
        forever #5 CLOCK = ~CLOCK;
    end

    initial begin
        repeat (20000) @(posedge CLOCK);
        err_total++;
        give_verdict();
    end

    initial begin
        err_total = 0; cmp_count = 0; RESET_N = 1'b0; PSEL = 1'b0;
        PENABLE = 1'b0; PWRITE = 1'b0; PADDR = 12'h000; PWDATA = 32'h0;
        SAMPLE_IN = '0; SLOT_START = 1'b0; SLOT_START_SEL = 1'b0;
        repeat (16) @(posedge CLOCK);
        RESET_N <= 1'b1;
        rd_chk(ba(tcm_pkg::IDX_MODE_A), 32'h0000_1C00);
        rd_chk(ba(tcm_pkg::IDX_CONN_A), 32'h0000_ADA5);
        rd_chk(ba(tcm_pkg::IDX_MODE_B), 32'h0000_1C00);
        rd_chk(ba(tcm_pkg::IDX_CONN_B), 32'h0000_ADA5);
        rd_chk(ba(tcm_pkg::IDX_MATH), 32'h0000_0000);
        chk_flag(er, 1'b0);
        chk_word(32'(SLOT_A_PATH), 32'h0000_0000);
        rd_chk(12'h100, 32'h0000_0000);
        chk_flag(er, 1'b1);
        apb(1'b1, ba(tcm_pkg::IDX_MATH) | 12'h002, 32'h0000_FFFF);
        chk_flag(er, 1'b1);
        rd_chk(ba(tcm_pkg::IDX_MATH), 32'h0000_0000);
        for (int r = 0; r < 8; r++) begin
            apb(1'b1, ba(tcm_pkg::IDX_MATH), {16'h0000, ROWS[r].math});
            apb(1'b1, ba(ROWS[r].slot ? tcm_pkg::IDX_ACC_B
                                       : tcm_pkg::IDX_ACC_A), 32'h0);
            start_pulse(ROWS[r].slot);
            for (int j = 0; j < 8; j++) begin
                send(ROWS[r].slot, 14'(1 << (j % 4)));
                if (j == 2)
                    send(!ROWS[r].slot, 14'h3FFF);
            end
            apb(1'b0, ba(ROWS[r].slot ? tcm_pkg::IDX_ACC_B
                                       : tcm_pkg::IDX_ACC_A), 32'h0);
            chk_word(rd, 32'($signed(ROWS[r].acc)));
        end
        run_seq(1'b0, 0);
        apb(1'b1, ba(tcm_pkg::IDX_CONN_A), 32'h0000_B065);
        repeat (2) @(posedge CLOCK);
        #1;
        chk_word(32'(SLOT_A_PATH), 32'h0000_0019);
        chk_word(32'(SLOT_B_PATH), 32'h0000_0000);
        apb(1'b1, ba(tcm_pkg::IDX_MODE_B), 32'h0000_1E80);
        apb(1'b1, ba(tcm_pkg::IDX_MATH), 32'h0000_0080);
        apb(1'b1, ba(tcm_pkg::IDX_CONN_B), 32'h0000_AE65);
        repeat (2) @(posedge CLOCK);
        #1;
        chk_word(32'(SLOT_B_PATH), 32'h0000_0017);
        chk_word(32'(SLOT_A_PATH), 32'h0000_0019);
        run_seq(1'b0, 4);
        run_seq(1'b1, 4);
        // Direct mode ignores chop signs; status shows pulse index 3
        apb(1'b1, ba(tcm_pkg::IDX_MATH), 32'h0000_0CE0);
        apb(1'b1, ba(tcm_pkg::IDX_ACC_B), 32'h0);
        for (int j = 0; j < 3; j++)
            send(1'b1, 14'(1 << j));
        rd_chk(ba(tcm_pkg::IDX_ACC_B), 32'h0000_0007);
        rd_chk(ba(tcm_pkg::IDX_STATUS), 32'h0000_00F8);
        // Reset in mid-sequence
        start_pulse(1'b1);
        repeat (3) @(posedge CLOCK);
        #1;
        chk_flag(SEQ_BUSY, 1'b1);
        @(posedge CLOCK);
        RESET_N <= 1'b0;
        repeat (2) @(posedge CLOCK);
        #1;
        chk_flag(SEQ_BUSY, 1'b0);
        chk_word(32'(SLOT_B_PATH), 32'h0000_0000);
        @(posedge CLOCK);
        RESET_N <= 1'b1;
        rd_chk(ba(tcm_pkg::IDX_CONN_B), 32'h0000_ADA5);
        rd_chk(ba(tcm_pkg::IDX_ACC_B), 32'h0000_0000);
        give_verdict();
    end
endmodule : tcm_top_tb
